// ==== common/sdcad_defines.svh ====
// Constants of the command and address front end.
//==========================================================================
// Operation
// - Address and control inputs are captured only on the rising crossing of the command clock.
// - The address bus carries the row address with row-open and the column address with read or write.
// - Address bit 10 on a read or write requests automatic precharge after the burst.
// - A precharge with bit 10 low closes the selected bank and with bit 10 high closes all banks.
// - A mode-set takes its operation code from the address inputs.
// - The three bank-select inputs name the bank of a row-open, read, write or single precharge.
// - A mode-set uses bank-select to pick one of four mode registers.
// - Clock-enable registered high enables internal clocking and registered low disables it.
// - Clock-enable low with all banks idle enters precharge power-down or self refresh, else active power-down.
// - Clock-enable is synchronous for power-down entry and exit and self refresh entry, asynchronous for self refresh exit.
// - Power-down gates all receivers but clock, clock-enable and termination; self refresh gates all but clock-enable.
// - Commands decode only when device-select is registered low.
// - The command comes from row strobe, column strobe, write-enable and device-select.
// - Termination follows the termination-control input unless a mode-set has disabled it.
`ifndef SDCAD_DEFINES_SVH
`define SDCAD_DEFINES_SVH
`define SDCAD_ADDR_W 15
`define SDCAD_BANK_W 3
`define SDCAD_NUM_BANKS 8
`define SDCAD_AP_BIT 10
`define SDCAD_MR_SEL_W 2
`define SDCAD_ODT_EN_BIT 2
`define SDCAD_OP_LMR 3'h0
`define SDCAD_OP_REF 3'h1
`define SDCAD_OP_PRE 3'h2
`define SDCAD_OP_ACT 3'h3
`define SDCAD_OP_WR 3'h4
`define SDCAD_OP_RD 3'h5
`define SDCAD_OP_NOP 3'h7
`define SDCAD_MR_RESET 15'h0000
`define SDCAD_EMR1_RESET 15'h0004
`endif

// ==== common/sdcad_pkg.sv ====
// Types shared by the command and address front end.
`include "sdcad_defines.svh"
package sdcad_pkg;
  typedef enum logic [2:0] {
    SDCAD_CMD_NONE, SDCAD_CMD_MODE_SET, SDCAD_CMD_REFRESH, SDCAD_CMD_PRECHARGE,
    SDCAD_CMD_ROW_OPEN, SDCAD_CMD_WRITE, SDCAD_CMD_READ
  } sdcad_cmd_type;
  typedef enum logic [2:0] {
    SDCAD_PWR_ACTIVE, SDCAD_PWR_PRE_PD, SDCAD_PWR_ACT_PD, SDCAD_PWR_SELF_REF
  } sdcad_pwr_type;
  typedef struct packed {
    logic valid;
    sdcad_cmd_type cmd;
    logic [`SDCAD_BANK_W-1:0] bank;
    logic [`SDCAD_ADDR_W-1:0] addr;
    logic auto_precharge;
    logic precharge_all;
  } sdcad_dec_type;
  typedef struct packed {
    logic select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
    logic [`SDCAD_BANK_W-1:0] bank;
    logic [`SDCAD_ADDR_W-1:0] addr;
  } sdcad_pins_type;
endpackage : sdcad_pkg

// ==== core/sdcad_sync.sv ====
// Three-stage input synchroniser with agreement detection.
`timescale 1ns/100ps
`default_nettype none
module sdcad_sync (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic din,
  output logic dout
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_dout;
  //==========================================================================
  // Synchroniser
  // Output changes only when the second and third stages agree.
  always_comb begin
    next_stage = {stage[1:0], din};
    next_dout = (stage[1] == stage[2]) ? stage[2] : dout;
  end
  // Registers the stages and the filtered level.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage <= 3'h0;
      dout <= 1'b0;
    end else begin
      stage <= next_stage;
      dout <= next_dout;
    end
  end
endmodule : sdcad_sync
`default_nettype wire

// ==== core/sdcad_front.sv ====
// Command and address decoder with clock-enable power management.
`timescale 1ns/100ps
`default_nettype none
`include "sdcad_defines.svh"
module sdcad_front
  import sdcad_pkg::*;
#(
  parameter int ADDR_W = `SDCAD_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmd_clk_rise,
  input wire logic clock_enable_pin,
  input wire logic termination_control,
  input wire sdcad_pins_type pins,
  output sdcad_dec_type dec,
  output logic [`SDCAD_NUM_BANKS-1:0] bank_open,
  output logic auto_precharge_pend,
  output logic [ADDR_W-1:0] base_mode_register,
  output logic [ADDR_W-1:0] extended_mode_register_1,
  output logic [ADDR_W-1:0] extended_mode_register_2,
  output logic [ADDR_W-1:0] extended_mode_register_3,
  output sdcad_pwr_type pwr_state,
  output logic clocking_enabled,
  output logic cmd_receivers_on,
  output logic termination_active
);
  logic cke_sync;
  logic cke_reg;
  logic cke_prev;
  logic next_cke_reg;
  logic next_cke_prev;
  sdcad_dec_type next_dec;
  logic [`SDCAD_NUM_BANKS-1:0] next_bank_open;
  logic next_auto_precharge_pend;
  logic [ADDR_W-1:0] next_mr0;
  logic [ADDR_W-1:0] next_mr1;
  logic [ADDR_W-1:0] next_mr2;
  logic [ADDR_W-1:0] next_mr3;
  sdcad_pwr_type next_pwr_state;
  logic next_clocking_enabled;
  logic next_cmd_receivers_on;
  logic next_termination_active;
  logic [2:0] strobes;
  logic sample;

  //==========================================================================
  // Clock-enable input
  // The asynchronous pin passes three synchroniser stages and the filtered output flip-flop before use.
  sdcad_sync u_cke_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .din(clock_enable_pin),
    .dout(cke_sync)
  );

  // Commands are taken only on the rising command-clock crossing.
  assign sample = cmd_clk_rise && cmd_receivers_on;
  assign strobes = {pins.row_strobe_n, pins.col_strobe_n,
                    pins.write_enable_n};

  //==========================================================================
  // Command decode
  // Builds the decoded command, bank state and mode registers.
  always_comb begin
    next_dec = '0;
    next_dec.cmd = SDCAD_CMD_NONE;
    next_bank_open = bank_open;
    next_auto_precharge_pend = 1'b0;
    next_mr0 = base_mode_register;
    next_mr1 = extended_mode_register_1;
    next_mr2 = extended_mode_register_2;
    next_mr3 = extended_mode_register_3;
    if (sample && cke_reg && !pins.select_n) begin
      next_dec.valid = 1'b1;
      next_dec.bank = pins.bank;
      next_dec.addr = pins.addr[ADDR_W-1:0];
      case (strobes)
        `SDCAD_OP_LMR: begin
          next_dec.cmd = SDCAD_CMD_MODE_SET;
          case (pins.bank[`SDCAD_MR_SEL_W-1:0])
            2'h0: next_mr0 = pins.addr[ADDR_W-1:0];
            2'h1: next_mr1 = pins.addr[ADDR_W-1:0];
            2'h2: next_mr2 = pins.addr[ADDR_W-1:0];
            default: next_mr3 = pins.addr[ADDR_W-1:0];
          endcase
        end
        `SDCAD_OP_REF: begin
          next_dec.cmd = SDCAD_CMD_REFRESH;
        end
        `SDCAD_OP_PRE: begin
          next_dec.cmd = SDCAD_CMD_PRECHARGE;
          if (pins.addr[`SDCAD_AP_BIT]) begin
            next_dec.precharge_all = 1'b1;
            next_bank_open = '0;
          end else begin
            next_bank_open[pins.bank] = 1'b0;
          end
        end
        `SDCAD_OP_ACT: begin
          next_dec.cmd = SDCAD_CMD_ROW_OPEN;
          next_bank_open[pins.bank] = 1'b1;
        end
        `SDCAD_OP_WR, `SDCAD_OP_RD: begin
          next_dec.cmd = (strobes == `SDCAD_OP_WR) ? SDCAD_CMD_WRITE
                                                    : SDCAD_CMD_READ;
          // Auto precharge marks the bank closed in the cycle the command is decoded.
          if (pins.addr[`SDCAD_AP_BIT]) begin
            next_dec.auto_precharge = 1'b1;
            next_auto_precharge_pend = 1'b1;
            next_bank_open[pins.bank] = 1'b0;
          end
        end
        default: begin
          next_dec.valid = 1'b0;
        end
      endcase
    end
  end

  // Registers the decode group.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec <= '0;
      bank_open <= '0;
      auto_precharge_pend <= 1'b0;
      base_mode_register <= ADDR_W'(`SDCAD_MR_RESET);
      extended_mode_register_1 <= ADDR_W'(`SDCAD_EMR1_RESET);
      extended_mode_register_2 <= '0;
      extended_mode_register_3 <= '0;
    end else begin
      dec <= next_dec;
      bank_open <= next_bank_open;
      auto_precharge_pend <= next_auto_precharge_pend;
      base_mode_register <= next_mr0;
      extended_mode_register_1 <= next_mr1;
      extended_mode_register_2 <= next_mr2;
      extended_mode_register_3 <= next_mr3;
    end
  end

  //==========================================================================
  // Power management
  // Clock-enable is registered on command edges, except that self refresh
  // exit follows the synchronised pin without waiting for the clock.
  always_comb begin
    next_cke_reg = cke_reg;
    next_cke_prev = cke_prev;
    next_pwr_state = pwr_state;
    if (cmd_clk_rise) begin
      next_cke_reg = cke_sync;
      next_cke_prev = cke_reg;
    end
    case (pwr_state)
      SDCAD_PWR_ACTIVE: begin
        if (cmd_clk_rise && !cke_sync && cke_reg) begin
          if (bank_open != '0) begin
            next_pwr_state = SDCAD_PWR_ACT_PD;
          end else if (!pins.select_n && strobes == `SDCAD_OP_REF) begin
            next_pwr_state = SDCAD_PWR_SELF_REF;
          end else begin
            next_pwr_state = SDCAD_PWR_PRE_PD;
          end
        end
      end
      SDCAD_PWR_PRE_PD, SDCAD_PWR_ACT_PD: begin
        if (cmd_clk_rise && cke_sync) begin
          next_pwr_state = SDCAD_PWR_ACTIVE;
        end
      end
      SDCAD_PWR_SELF_REF: begin
        if (cke_sync) begin
          next_pwr_state = SDCAD_PWR_ACTIVE;
          next_cke_reg = 1'b1;
        end
      end
      default: begin
        next_pwr_state = SDCAD_PWR_ACTIVE;
      end
    endcase
    next_clocking_enabled = next_cke_reg;
    next_cmd_receivers_on = (next_pwr_state == SDCAD_PWR_ACTIVE);
    // Termination stays off in self refresh and when mode-set disabled it.
    next_termination_active = termination_control && next_cke_reg_ok();
  end

  // Termination is allowed outside self refresh when enabled by mode-set.
  function automatic logic next_cke_reg_ok();
    next_cke_reg_ok = extended_mode_register_1[`SDCAD_ODT_EN_BIT]
                      && (pwr_state != SDCAD_PWR_SELF_REF);
  endfunction : next_cke_reg_ok

  // Registers the power group.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cke_reg <= 1'b0;
      cke_prev <= 1'b0;
      pwr_state <= SDCAD_PWR_ACTIVE;
      clocking_enabled <= 1'b0;
      cmd_receivers_on <= 1'b1;
      termination_active <= 1'b0;
    end else begin
      cke_reg <= next_cke_reg;
      cke_prev <= next_cke_prev;
      pwr_state <= next_pwr_state;
      clocking_enabled <= next_clocking_enabled;
      cmd_receivers_on <= next_cmd_receivers_on;
      termination_active <= next_termination_active;
    end
  end

  //==========================================================================
  // Checks
  sequence s_cmd_seen;
    cmd_clk_rise && cmd_receivers_on && cke_reg;
  endsequence

  // A step from full operation into one of the low-power states.
  sequence s_power_down_entry;
    pwr_state == SDCAD_PWR_ACTIVE ##1 pwr_state != SDCAD_PWR_ACTIVE;
  endsequence

  // A power-down exit request on a command-clock crossing.
  sequence s_pd_exit_request;
    (pwr_state == SDCAD_PWR_PRE_PD || pwr_state == SDCAD_PWR_ACT_PD)
    && cmd_clk_rise && cke_sync;
  endsequence

  // Command acceptance and decode.
  chk_select_gates_cmd: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (s_cmd_seen and pins.select_n) |=> !dec.valid)
    else $error("Command decoded while device-select was high.");
  chk_no_sample_idle: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !cmd_clk_rise |=> !dec.valid)
    else $error("Command decoded without a command-clock edge.");
  chk_cke_low_gates: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (cmd_clk_rise && !cke_reg) |=> !dec.valid)
    else $error("Command decoded while clock-enable was registered low.");
  chk_noop_refused: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (s_cmd_seen and (!pins.select_n && strobes == `SDCAD_OP_NOP))
    |=> !dec.valid)
    else $error("No-operation produced a decoded command.");
  chk_read_decode: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (s_cmd_seen and (!pins.select_n && strobes == `SDCAD_OP_RD))
    |=> dec.valid && dec.cmd == SDCAD_CMD_READ)
    else $error("Read strobe levels not decoded as a read.");
  chk_prech_all: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dec.valid && dec.cmd == SDCAD_CMD_PRECHARGE && dec.precharge_all)
    |-> bank_open == '0)
    else $error("Precharge-all left a bank open.");
  chk_prech_one: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dec.valid && dec.cmd == SDCAD_CMD_PRECHARGE && !dec.precharge_all)
    |-> !bank_open[dec.bank])
    else $error("Single-bank precharge left its bank open.");
  chk_row_open_bank: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dec.valid && dec.cmd == SDCAD_CMD_ROW_OPEN) |-> bank_open[dec.bank])
    else $error("Row-open did not mark its bank.");
  chk_auto_prech: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dec.valid && (dec.cmd == SDCAD_CMD_READ || dec.cmd == SDCAD_CMD_WRITE))
    |-> dec.auto_precharge == dec.addr[`SDCAD_AP_BIT]
        && (!dec.addr[`SDCAD_AP_BIT] || !bank_open[dec.bank]))
    else $error("Auto precharge does not follow address bit 10.");
  // Mode registers.
  chk_mode_set_base: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dec.valid && dec.cmd == SDCAD_CMD_MODE_SET && dec.bank[1:0] == 2'h0)
    |-> base_mode_register == dec.addr)
    else $error("Base mode register not loaded.");
  chk_mode_set_ext1: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dec.valid && dec.cmd == SDCAD_CMD_MODE_SET && dec.bank[1:0] == 2'h1)
    |-> extended_mode_register_1 == dec.addr)
    else $error("First extended mode register not loaded.");
  chk_mode_set_ext2: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dec.valid && dec.cmd == SDCAD_CMD_MODE_SET && dec.bank[1:0] == 2'h2)
    |-> extended_mode_register_2 == dec.addr)
    else $error("Second extended mode register not loaded.");
  chk_mode_set_ext3: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dec.valid && dec.cmd == SDCAD_CMD_MODE_SET && dec.bank[1:0] == 2'h3)
    |-> extended_mode_register_3 == dec.addr)
    else $error("Third extended mode register not loaded.");
  // Clock-enable and power states.
  chk_active_pd: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (pwr_state == SDCAD_PWR_ACTIVE && cmd_clk_rise && !cke_sync && cke_reg
     && bank_open != '0) |=> pwr_state == SDCAD_PWR_ACT_PD)
    else $error("Active power-down not entered with a row open.");
  chk_pd_entry_cke: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_power_down_entry |-> cke_prev && !cke_reg)
    else $error("Low-power state entered without clock-enable falling.");
  chk_pd_exit: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_pd_exit_request |=> pwr_state == SDCAD_PWR_ACTIVE && clocking_enabled)
    else $error("Power-down exit not taken on clock-enable high.");
  chk_pd_no_decode: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (pwr_state != SDCAD_PWR_ACTIVE && cmd_clk_rise) |=> !dec.valid)
    else $error("Command decoded while the receivers were off.");
  chk_sr_exit: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (pwr_state == SDCAD_PWR_SELF_REF && cke_sync)
    |=> pwr_state == SDCAD_PWR_ACTIVE ##1 cmd_receivers_on)
    else $error("Self refresh exit not taken without a clock edge.");
  chk_clocking: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    cmd_clk_rise |=> clocking_enabled == $past(cke_sync))
    else $error("Clocking enable does not follow clock-enable.");
  chk_sr_no_term: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    pwr_state == SDCAD_PWR_SELF_REF |=> !termination_active)
    else $error("Termination on during self refresh.");
  chk_odt_off: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !extended_mode_register_1[`SDCAD_ODT_EN_BIT] |=> !termination_active)
    else $error("Termination on while disabled by mode-set.");
endmodule : sdcad_front
`default_nettype wire

// ==== tb/sdcad_ctl_model.sv ====
// Behavioural memory controller that drives the command and address pins.
`timescale 1ns/100ps
`default_nettype none
module sdcad_ctl_model
  import sdcad_pkg::*;
(
  input wire logic sys_clk,
  output logic cmd_clk_rise,
  output logic clock_enable_pin,
  output logic termination_control,
  output sdcad_pins_type pins
);
  //========================================================================
  // Command clock and pin drivers
  logic run = 1'b1;
  // All lines start deselected with clock-enable low.
  initial begin
    cmd_clk_rise = 1'b0;
    clock_enable_pin = 1'b0;
    termination_control = 1'b0;
    pins = '1;
  end
  // A rising crossing every second cycle; it stands still when stopped.
  always @(negedge sys_clk) begin
    cmd_clk_rise <= run & ~cmd_clk_rise;
  end
  // Sets one command up so that the next rising crossing takes it.
  task automatic issue(input logic s, input logic [2:0] op,
      input logic [2:0] b, input logic [14:0] a);
    @(negedge sys_clk);
    while (cmd_clk_rise) @(negedge sys_clk);
    pins = {s, op, b, a};
    @(negedge sys_clk);
  endtask : issue
  // Deselects; released bank and address lines show the inverse value.
  task automatic idle();
    @(negedge sys_clk);
    pins = {1'b1, 3'h7, ~pins.bank, ~pins.addr};
  endtask : idle
  // Drives the clock-enable and termination-control levels.
  task automatic set_lines(input logic c, input logic t);
    @(negedge sys_clk);
    clock_enable_pin = c;
    termination_control = t;
  endtask : set_lines
  // Starts or stops the command clock.
  task automatic set_run(input logic r);
    @(negedge sys_clk);
    // Non-blocking so the crossing generator sees a settled value.
    run <= r;
  endtask : set_run
endmodule : sdcad_ctl_model
`default_nettype wire

// ==== tb/sdram_cmd_addr_input_decode_tb.sv ====
// Self-checking bench for the command and address front end.
`timescale 1ns/100ps
`default_nettype none
`include "sdcad_defines.svh"
module sdram_cmd_addr_input_decode_tb;
  import sdcad_pkg::*;
  //========================================================================
  // Wiring
  logic sys_clk;
  logic reset_n;
  logic cmd_clk_rise;
  logic cke;
  logic term;
  sdcad_pins_type pins;
  sdcad_dec_type dec;
  logic [7:0] bank_open;
  logic ap_pend;
  logic [14:0] mreg0, mreg1, mreg2, mreg3;
  sdcad_pwr_type pwr;
  logic clk_en;
  logic rx_on;
  logic term_on;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  sdcad_front sdcad_front_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .cmd_clk_rise(cmd_clk_rise), .clock_enable_pin(cke),
    .termination_control(term), .pins(pins), .dec(dec),
    .bank_open(bank_open), .auto_precharge_pend(ap_pend),
    .base_mode_register(mreg0), .extended_mode_register_1(mreg1),
    .extended_mode_register_2(mreg2), .extended_mode_register_3(mreg3),
    .pwr_state(pwr), .clocking_enabled(clk_en),
    .cmd_receivers_on(rx_on), .termination_active(term_on));
  sdcad_ctl_model sdcad_ctl_model_i (.sys_clk(sys_clk),
    .cmd_clk_rise(cmd_clk_rise), .clock_enable_pin(cke),
    .termination_control(term), .pins(pins));
  //========================================================================
  // Helpers
  // Clock of 4 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Cuts a hang short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  // Compares one bit.
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk_bit
  // Compares a vector.
  task automatic chk_vec(input string what, input logic [14:0] e,
      input logic [14:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk_vec
  // Issues one command through the controller model.
  task automatic cmd(input logic s, input logic [2:0] op,
      input logic [2:0] b, input logic [14:0] a);
    sdcad_ctl_model_i.issue(s, op, b, a);
  endtask : cmd
  // Waits a bounded time for a power state, then compares it.
  task automatic wait_pwr(input sdcad_pwr_type p);
    for (int i = 0; i < 40 && pwr !== p; i++) @(negedge sys_clk);
    chk_vec("pwr_state", p, pwr);
  endtask : wait_pwr
  //========================================================================
  // Scenarios
  // Values held during reset.
  task automatic t_reset();
    chk_vec("mode reg 0", 15'h0000, mreg0);
    chk_vec("mode reg 1", 15'h0004, mreg1);
    chk_vec("pwr_state", SDCAD_PWR_ACTIVE, pwr);
    chk_bit("clocking_enabled", 1'b0, clk_en);
    chk_bit("termination_active", 1'b0, term_on);
  endtask : t_reset
  // Row-open, write, read, precharge and refresh codes, a no-op and a deselected command.
  task automatic t_decode();
    logic [2:0] ops [5] = '{`SDCAD_OP_ACT, `SDCAD_OP_WR, `SDCAD_OP_RD,
      `SDCAD_OP_PRE, `SDCAD_OP_REF};
    sdcad_cmd_type e [5] = '{SDCAD_CMD_ROW_OPEN, SDCAD_CMD_WRITE,
      SDCAD_CMD_READ, SDCAD_CMD_PRECHARGE, SDCAD_CMD_REFRESH};
    for (int i = 0; i < 5; i++) begin
      cmd(1'b0, ops[i], 3'h2, 15'h0123 + 15'(i));
      chk_bit("dec.valid", 1'b1, dec.valid);
      chk_vec("dec.cmd", e[i], dec.cmd);
      if (i < 3) begin
        chk_vec("dec.bank", 15'h0002, 15'(dec.bank));
        chk_vec("dec.addr", 15'h0123 + 15'(i), dec.addr);
      end
    end
    cmd(1'b0, `SDCAD_OP_NOP, 3'h2, 15'h0000);
    chk_bit("no-op valid", 1'b0, dec.valid);
    cmd(1'b1, `SDCAD_OP_ACT, 3'h2, 15'h0000);
    chk_bit("deselected valid", 1'b0, dec.valid);
    chk_vec("bank_open", 15'h0000, 15'(bank_open));
  endtask : t_decode
  // Back-to-back row opens, auto precharge, single and all-bank precharge.
  task automatic t_banks();
    cmd(1'b0, `SDCAD_OP_ACT, 3'h1, 15'h0011);
    cmd(1'b0, `SDCAD_OP_ACT, 3'h6, 15'h0066);
    cmd(1'b0, `SDCAD_OP_ACT, 3'h3, 15'h7abc);
    chk_vec("bank_open", 15'h004a, 15'(bank_open));
    cmd(1'b0, `SDCAD_OP_WR, 3'h3, 15'h0400);
    chk_bit("auto_precharge_pend", 1'b1, ap_pend);
    chk_bit("dec.auto_precharge", 1'b1, dec.auto_precharge);
    chk_vec("bank_open", 15'h0042, 15'(bank_open));
    @(negedge sys_clk);
    chk_bit("held pins valid", 1'b0, dec.valid);
    cmd(1'b0, `SDCAD_OP_PRE, 3'h1, 15'h0000);
    chk_vec("bank_open", 15'h0040, 15'(bank_open));
    chk_bit("precharge_all", 1'b0, dec.precharge_all);
    cmd(1'b0, `SDCAD_OP_PRE, 3'h0, 15'h0400);
    chk_vec("bank_open", 15'h0000, 15'(bank_open));
    chk_bit("precharge_all", 1'b1, dec.precharge_all);
  endtask : t_banks
  // Loads all four mode registers, then gates termination through one.
  task automatic t_mode();
    logic [14:0] v [4] = '{15'h0a51, 15'h0104, 15'h1c22, 15'h7ff3};
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, `SDCAD_OP_LMR, 3'(i), v[i]);
      chk_vec("dec.cmd", SDCAD_CMD_MODE_SET, dec.cmd);
    end
    chk_vec("mode reg 0", v[0], mreg0);
    chk_vec("mode reg 1", v[1], mreg1);
    chk_vec("mode reg 2", v[2], mreg2);
    chk_vec("mode reg 3", v[3], mreg3);
    sdcad_ctl_model_i.set_lines(1'b1, 1'b1);
    repeat (8) @(negedge sys_clk);
    chk_bit("termination_active", 1'b1, term_on);
    cmd(1'b0, `SDCAD_OP_LMR, 3'h1, 15'h0100);
    repeat (8) @(negedge sys_clk);
    chk_bit("termination_active", 1'b0, term_on);
    sdcad_ctl_model_i.set_lines(1'b1, 1'b0);
  endtask : t_mode
  // Active and precharge power-down, then self refresh left without clock.
  task automatic t_power();
    cmd(1'b0, `SDCAD_OP_ACT, 3'h4, 15'h0044);
    sdcad_ctl_model_i.set_lines(1'b0, 1'b0);
    wait_pwr(SDCAD_PWR_ACT_PD);
    chk_bit("cmd_receivers_on", 1'b0, rx_on);
    chk_bit("clocking_enabled", 1'b0, clk_en);
    cmd(1'b0, `SDCAD_OP_ACT, 3'h5, 15'h0055);
    chk_bit("power-down valid", 1'b0, dec.valid);
    sdcad_ctl_model_i.idle();
    sdcad_ctl_model_i.set_lines(1'b1, 1'b0);
    wait_pwr(SDCAD_PWR_ACTIVE);
    chk_bit("cmd_receivers_on", 1'b1, rx_on);
    chk_vec("bank_open", 15'h0010, 15'(bank_open));
    cmd(1'b0, `SDCAD_OP_PRE, 3'h0, 15'h0400);
    sdcad_ctl_model_i.idle();
    sdcad_ctl_model_i.set_lines(1'b0, 1'b0);
    wait_pwr(SDCAD_PWR_PRE_PD);
    sdcad_ctl_model_i.set_lines(1'b1, 1'b0);
    wait_pwr(SDCAD_PWR_ACTIVE);
    cmd(1'b0, `SDCAD_OP_REF, 3'h0, 15'h0000);
    sdcad_ctl_model_i.set_lines(1'b0, 1'b0);
    wait_pwr(SDCAD_PWR_SELF_REF);
    chk_bit("cmd_receivers_on", 1'b0, rx_on);
    sdcad_ctl_model_i.set_run(1'b0);
    sdcad_ctl_model_i.idle();
    sdcad_ctl_model_i.set_lines(1'b1, 1'b0);
    wait_pwr(SDCAD_PWR_ACTIVE);
    sdcad_ctl_model_i.set_run(1'b1);
  endtask : t_power
  // Reset in mid-run clears state; decode resumes once clock-enable registers.
  task automatic t_midreset();
    cmd(1'b0, `SDCAD_OP_ACT, 3'h7, 15'h0077);
    reset_n = 1'b0;
    @(negedge sys_clk);
    chk_vec("bank_open", 15'h0000, 15'(bank_open));
    chk_bit("clocking_enabled", 1'b0, clk_en);
    chk_vec("mode reg 1", 15'h0004, mreg1);
    reset_n = 1'b1;
    for (int i = 0; i < 40 && clk_en !== 1'b1; i++) @(negedge sys_clk);
    chk_bit("clocking_enabled", 1'b1, clk_en);
    cmd(1'b0, `SDCAD_OP_ACT, 3'h2, 15'h0022);
    chk_vec("bank_open", 15'h0004, 15'(bank_open));
  endtask : t_midreset
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  //========================================================================
  // Main sequence
  // Reset for ten cycles, raise clock-enable, then run every scenario.
  initial begin
    reset_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    t_reset();
    reset_n = 1'b1;
    sdcad_ctl_model_i.set_lines(1'b1, 1'b0);
    for (int i = 0; i < 40 && clk_en !== 1'b1; i++) @(negedge sys_clk);
    chk_bit("clocking_enabled", 1'b1, clk_en);
    t_decode();
    t_banks();
    t_mode();
    t_power();
    t_midreset();
    finish_test();
  end
endmodule : sdram_cmd_addr_input_decode_tb
`default_nettype wire
